// [rtl/gmc_cap_rom.sv]
// constant capability structure, one byte by index
// assumes index below the structure size; others read zero
`timescale 1ns/1ps
`default_nettype none
module gmc_cap_rom
    import gmc_pkg::*;
(
    input  wire logic [3:0] byteIdx,
    output logic      [7:0] byteData
);
    // --------------------------------------------------------------
    // lookup
    // --------------------------------------------------------------
    always_comb
    begin
        byteData = 8'h00;
        if (int'(byteIdx) < CAP_STRUCT_BYTES)
        begin
            // fields fixed, reserved upper bytes zero
            byteData = CAP_STRUCT_VALUE[{byteIdx, 3'h0} +: 8];
        end
    end
endmodule // gmc_cap_rom
`default_nettype wire

// [rtl/gmc_config_regs.sv]
// read-only configuration bank of the graphics function
// assumes one configuration request at a time, dword addressed
`timescale 1ns/1ps
`default_nettype none
module gmc_config_regs
    import gmc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        cfgValid,
    input  wire logic        cfgWrite,
    input  wire logic [5:0]  cfgDword,
    input  wire logic [3:0]  cfgByteEn,
    input  wire logic [31:0] cfgWrData,
    input  wire logic [15:0] hostGfxCtrl,
    input  wire logic        smmMemoryLock,
    output logic             cfgDone,
    output logic      [31:0] cfgRdData,
    output logic             cfgHit,
    output logic             writeIgnored,
    output logic             gfxCtrlLocked,
    output logic             vgaClaim,
    output logic      [7:0]  subClassCode,
    output logic      [3:0]  preallocMb,
    output logic             preallocReserved
);
    typedef struct packed {
        logic        done;
        logic [31:0] rdData;
        logic        hit;
        logic        wrIgn;
    } gmc_bus_s;

    gmc_bus_s st;
    gmc_bus_s next_st;
    logic [31:0] laneData;
    logic [3:0]  laneHit;

    gmc_gfx_if gfx ();

    gmc_gfx_ctrl u_gfx (
        .sys_clk       (sys_clk),
        .rst           (rst),
        .ce            (ce),
        .hostGfxCtrl   (hostGfxCtrl),
        .smmMemoryLock (smmMemoryLock),
        .gfx           (gfx.src)
    );

    // --------------------------------------------------------------
    // per byte lane decode
    // --------------------------------------------------------------
    for (genvar g = 0; g < 4; g++)
    begin : g_lane
        logic [7:0] addr;
        logic [7:0] capIdx;
        logic [7:0] capByte;
        logic [7:0] laneByte;
        logic       laneSel;
        assign addr   = {cfgDword, 2'(g)};
        assign capIdx = addr - OFS_CAP_STRUCT;
        // one driver per lane slice keeps the shared vectors clean
        assign laneData[g*8 +: 8] = laneByte;
        assign laneHit[g]         = laneSel;

        gmc_cap_rom u_rom (
            .byteIdx  (capIdx[3:0]),
            .byteData (capByte)
        );

        always_comb
        begin
            laneByte = 8'h00;
            laneSel  = 1'b1;
            if (addr == OFS_MAX_LATENCY)
            begin
                laneByte = MAX_LATENCY_VALUE;
            end
            else if (addr == OFS_CAP_PTR)
            begin
                laneByte = CAP_PTR_VALUE;
            end
            else if (addr >= OFS_CAP_STRUCT && addr <= OFS_CAP_LAST)
            begin
                laneByte = capByte;
            end
            else if (addr == OFS_GFX_CTRL_LO)
            begin
                laneByte = gfx.ctrlValue[7:0];
            end
            else if (addr == OFS_GFX_CTRL_HI)
            begin
                laneByte = gfx.ctrlValue[15:8];
            end
            else
            begin
                laneSel = 1'b0;
            end
            if (!cfgByteEn[g])
            begin
                laneByte = 8'h00;
                laneSel  = 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // request handling
    // --------------------------------------------------------------
    // write data is never stored: every register here is read-only
    always_comb
    begin
        next_st = st;
        if (ce)
        begin
            next_st.done  = cfgValid;
            next_st.hit   = cfgValid && (|laneHit);
            next_st.wrIgn = cfgValid && cfgWrite && (|laneHit);
            next_st.rdData = 32'h0;
            if (cfgValid && !cfgWrite)
            begin
                next_st.rdData = laneData;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign cfgDone          = st.done;
    assign cfgRdData        = st.rdData;
    assign cfgHit           = st.hit;
    assign writeIgnored     = st.wrIgn;
    assign gfxCtrlLocked    = gfx.locked;
    assign vgaClaim         = gfx.vgaClaim;
    assign subClassCode     = gfx.subClass;
    assign preallocMb       = gfx.preallocMb;
    assign preallocReserved = gfx.preallocReserved;

    logic unusedWrData;
    assign unusedWrData = ^cfgWrData;
endmodule // gmc_config_regs
`default_nettype wire

// [rtl/gmc_gfx_ctrl.sv]
// graphics control mirror with lock and vga claim decode
// assumes host bridge value and lock are synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
module gmc_gfx_ctrl
    import gmc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [15:0] hostGfxCtrl,
    input  wire logic        smmMemoryLock,
    gmc_gfx_if.src           gfx
);
    typedef struct packed {
        logic        locked;
        logic [15:0] value;
        logic        claim;
        logic [7:0]  subClass;
        logic [3:0]  mb;
        logic        rsvd;
    } gmc_gfx_s;

    gmc_gfx_s st;
    gmc_gfx_s next_st;
    logic [2:0] sel;

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        sel = 3'h0;
        if (ce)
        begin
            // lock is sticky until reset
            next_st.locked = st.locked | smmMemoryLock;
            // follow host while unlocked, reserved bits dropped
            if (!st.locked && !smmMemoryLock)
            begin
                next_st.value = hostGfxCtrl & GFX_CTRL_MASK;
            end
            sel = next_st.value[PREALLOC_LSB +: 3];
            unique case (sel)
                PREALLOC_NONE: next_st.mb = SIZE_NONE_MB;
                PREALLOC_1MB:  next_st.mb = SIZE_1_MB;
                PREALLOC_8MB:  next_st.mb = SIZE_8_MB;
                default:       next_st.mb = SIZE_NONE_MB;
            endcase
            next_st.rsvd = (sel != PREALLOC_NONE) && (sel != PREALLOC_1MB)
                         && (sel != PREALLOC_8MB);
            // no memory or vga disabled both drop the claim
            next_st.claim = (sel != PREALLOC_NONE)
                          && !next_st.value[VGA_DIS_BIT];
            next_st.subClass = next_st.claim ? SUBCLASS_VGA
                                             : SUBCLASS_OTHER;
        end
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st <= '{locked: 1'b0, value: GFX_CTRL_RESET, claim: 1'b1,
                    subClass: SUBCLASS_VGA, mb: SIZE_8_MB, rsvd: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign gfx.ctrlValue        = st.value;
    assign gfx.locked           = st.locked;
    assign gfx.vgaClaim         = st.claim;
    assign gfx.subClass         = st.subClass;
    assign gfx.preallocMb       = st.mb;
    assign gfx.preallocReserved = st.rsvd;
endmodule // gmc_gfx_ctrl
`default_nettype wire

// [rtl/gmc_gfx_if.sv]
// carries the decoded graphics control state inside the bank
// assumes one driver module and one reader module
`timescale 1ns/1ps
`default_nettype none
interface gmc_gfx_if;
    logic [15:0] ctrlValue;
    logic        locked;
    logic        vgaClaim;
    logic [7:0]  subClass;
    logic [3:0]  preallocMb;
    logic        preallocReserved;

    modport src (output ctrlValue, locked, vgaClaim, subClass,
                 preallocMb, preallocReserved);
    modport snk (input  ctrlValue, locked, vgaClaim, subClass,
                 preallocMb, preallocReserved);
endinterface
`default_nettype wire

// [rtl/gmc_pkg.sv]
// constants for the graphics mirror configuration bank
// assumes byte offsets in the graphics function's configuration space
//
// Contract
// - max latency register is read-only and reads zero.
// - mirrored capabilities pointer is read-only and reads e0h.
// - capability structure version field, bits 27:24, reads 0001b.
// - capability structure length field, bits 23:16, reads 09h.
// - next capability pointer field, bits 15:8, reads 00h.
// - capability type code field, bits 7:0, reads 1001b.
// - preallocation select: 000 none, 001 1 MB, 011 8 MB, others reserved.
// - select 000 means no vga claim and sub-class 80h.
// - vga disable 0 with a select other than 000 means vga cycles claimed and sub-class 00.
// - vga disable 1 means no vga claim and sub-class 80h.
// - smm memory lock set makes graphics control locked and read-only.
package gmc_pkg;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_MAX_LATENCY = 8'h3f;
    localparam logic [7:0] OFS_CAP_PTR     = 8'h44;
    localparam logic [7:0] OFS_CAP_STRUCT  = 8'h48;
    localparam logic [7:0] OFS_CAP_LAST    = 8'h51;
    localparam logic [7:0] OFS_GFX_CTRL_LO = 8'h52;
    localparam logic [7:0] OFS_GFX_CTRL_HI = 8'h53;
    localparam int         CAP_STRUCT_BYTES = 10;

    // ----------------------------------------------------------------
    // fixed values
    // ----------------------------------------------------------------
    localparam logic [7:0]  MAX_LATENCY_VALUE  = 8'h00;
    localparam logic [7:0]  CAP_PTR_VALUE      = 8'he0;
    localparam logic [3:0]  CAP_VERSION        = 4'h1;
    localparam logic [7:0]  CAP_LENGTH         = 8'h09;
    localparam logic [7:0]  CAP_NEXT           = 8'h00;
    localparam logic [7:0]  CAP_TYPE_CODE      = 8'h09;
    localparam logic [79:0] CAP_STRUCT_VALUE   =
        {52'h0, CAP_VERSION, CAP_LENGTH, CAP_NEXT, CAP_TYPE_CODE};

    // ----------------------------------------------------------------
    // graphics control layout
    // ----------------------------------------------------------------
    localparam logic [15:0] GFX_CTRL_RESET = 16'h0030;
    localparam logic [15:0] GFX_CTRL_MASK  = 16'h0072;
    localparam int          PREALLOC_LSB   = 4;
    localparam int          VGA_DIS_BIT    = 1;
    localparam logic [2:0]  PREALLOC_NONE  = 3'h0;
    localparam logic [2:0]  PREALLOC_1MB   = 3'h1;
    localparam logic [2:0]  PREALLOC_8MB   = 3'h3;
    localparam logic [3:0]  SIZE_NONE_MB   = 4'h0;
    localparam logic [3:0]  SIZE_1_MB      = 4'h1;
    localparam logic [3:0]  SIZE_8_MB      = 4'h8;
    localparam logic [7:0]  SUBCLASS_VGA   = 8'h00;
    localparam logic [7:0]  SUBCLASS_OTHER = 8'h80;

endpackage

// [testbench/gmc_config_monitor.sv]
// port checker for the graphics mirror configuration bank
// assumes it is bound to gmc_config_regs and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module gmc_config_monitor
    import gmc_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        cfgValid,
    input wire logic        cfgWrite,
    input wire logic [5:0]  cfgDword,
    input wire logic [3:0]  cfgByteEn,
    input wire logic [31:0] cfgWrData,
    input wire logic [15:0] hostGfxCtrl,
    input wire logic        smmMemoryLock,
    input wire logic        cfgDone,
    input wire logic [31:0] cfgRdData,
    input wire logic        cfgHit,
    input wire logic        writeIgnored,
    input wire logic        gfxCtrlLocked,
    input wire logic        vgaClaim,
    input wire logic [7:0]  subClassCode,
    input wire logic [3:0]  preallocMb,
    input wire logic        preallocReserved
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // full-dword read taken, answered at the next enabled edge
    // ------------------------------------------------------------
    sequence s_rd(logic [5:0] d);
        ce && cfgValid && !cfgWrite && cfgDword == d && cfgByteEn == 4'hf
            ##1 ce;
    endsequence
    property p_done;
        ce && cfgValid ##1 ce |-> cfgDone;
    endproperty
    a_done: assert property (p_done) else $error("no done");
    property p_idle;
        ce && !cfgValid ##1 ce |-> !cfgDone && !cfgHit && !writeIgnored;
    endproperty
    a_idle: assert property (p_idle) else $error("stray done");
    property p_wr_zero;
        ce && cfgValid && cfgWrite ##1 ce |-> cfgRdData == 32'h0;
    endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("write data");
    property p_max_latency;
        s_rd(6'h0f) |-> cfgRdData[31:24] == 8'h00 && cfgHit;
    endproperty
    a_max_latency: assert property (p_max_latency) else $error("max latency");
    property p_capability_pointer;
        s_rd(6'h11) |-> cfgRdData[7:0] == 8'he0 && cfgHit;
    endproperty
    a_capability_pointer: assert property (p_capability_pointer) else $error("cap ptr");
    property p_capid;
        s_rd(6'h12) |-> cfgRdData == 32'h01090009;
    endproperty
    a_capid: assert property (p_capid) else $error("capability_type_code");
    property p_sub;
        subClassCode == (vgaClaim ? 8'h00 : 8'h80);
    endproperty
    a_sub: assert property (p_sub) else $error("sub-class");
    property p_rsv;
        preallocReserved |-> preallocMb == 4'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved size");
    property p_lock;
        ce && smmMemoryLock |=> gfxCtrlLocked [*3];
    endproperty
    a_lock: assert property (p_lock) else $error("lock lost");
    // locked mirror must not follow the host any more
    property p_freeze;
        gfxCtrlLocked |=> $stable(vgaClaim) && $stable(preallocMb);
    endproperty
    a_freeze: assert property (p_freeze) else $error("locked moved");
endmodule // gmc_config_monitor
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench for the graphics mirror configuration bank
// assumes ce drops once to check the freeze; the model tracks the mirror
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import gmc_pkg::*;
    logic sys_clk = 0, rst = 1, ce = 1, cfgValid = 0, cfgWrite = 0;
    logic [5:0]  cfgDword = 0;
    logic [3:0]  cfgByteEn = 0, preallocMb;
    logic [31:0] cfgWrData = 0, cfgRdData;
    logic [15:0] hostGfxCtrl = 0, mCtrl;
    logic smmMemoryLock = 0, mLock, cfgDone, cfgHit, writeIgnored;
    logic gfxCtrlLocked, vgaClaim, preallocReserved;
    logic [7:0]  subClassCode;
    int error_cnt = 0, n_compared = 0;
    always #5 sys_clk = ~sys_clk;
    gmc_config_regs u_gmc_config_regs (
        .sys_clk          (sys_clk),
        .rst              (rst),
        .ce               (ce),
        .cfgValid         (cfgValid),
        .cfgWrite         (cfgWrite),
        .cfgDword         (cfgDword),
        .cfgByteEn        (cfgByteEn),
        .cfgWrData        (cfgWrData),
        .hostGfxCtrl      (hostGfxCtrl),
        .smmMemoryLock    (smmMemoryLock),
        .cfgDone          (cfgDone),
        .cfgRdData        (cfgRdData),
        .cfgHit           (cfgHit),
        .writeIgnored     (writeIgnored),
        .gfxCtrlLocked    (gfxCtrlLocked),
        .vgaClaim         (vgaClaim),
        .subClassCode     (subClassCode),
        .preallocMb       (preallocMb),
        .preallocReserved (preallocReserved)
    );
    // ------------------------------------------------------------
    // reference model of the mirror and lock
    // ------------------------------------------------------------
    always @(posedge sys_clk or posedge rst)
        if (rst)
        begin
            mCtrl <= 16'h0030;
            mLock <= 1'b0;
        end
        else if (ce)
        begin
            if (smmMemoryLock)
                mLock <= 1'b1;
            else if (!mLock)
                mCtrl <= hostGfxCtrl & 16'h0072;
        end
    function automatic logic [7:0] expByte(input logic [7:0] o);
        logic [31:0] cap;
        cap = 32'h01090009;
        if (o == 8'h44) return 8'he0;
        if (o >= 8'h48 && o <= 8'h4b) return cap[8*(o-8'h48) +: 8];
        if (o == 8'h52) return mCtrl[7:0];
        if (o == 8'h53) return mCtrl[15:8];
        return 8'h00;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    // one request, held until the taking edge, result checked just after it
    task automatic cfg(input logic w, input logic [5:0] d,
                       input logic [3:0] en);
        logic [31:0] ed;
        logic [7:0]  o;
        logic        h;
        ed = 0;
        h = 0;
        @(posedge sys_clk);
        cfgValid <= 1;
        cfgWrite <= w;
        cfgDword <= d;
        cfgByteEn <= en;
        cfgWrData <= $urandom;
        @(posedge sys_clk);
        for (int g = 0; g < 4; g++)
            if (en[g])
            begin
                o = {d, g[1:0]};
                h |= o == 8'h3f || o == 8'h44 || (o >= 8'h48 && o <= 8'h53);
                if (!w) ed[8*g +: 8] = expByte(o);
            end
        cfgValid <= 0;
        #1;
        chk("done", 1, cfgDone);
        chk("hit", h, cfgHit);
        chk("data", ed, cfgRdData);
        chk("wign", w & h, writeIgnored);
    endtask
    task automatic chkDec;
        logic [2:0] s;
        logic       c;
        s = mCtrl[6:4];
        c = s != 3'h0 && !mCtrl[1];
        chk("claim", c, vgaClaim);
        chk("sub", c ? 8'h00 : 8'h80, subClassCode);
        chk("mb", s == 1 ? 1 : s == 3 ? 8 : 0, preallocMb);
        chk("rsv", s == 2 || s > 3, preallocReserved);
        chk("lock", mLock, gfxCtrlLocked);
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        end_of_test;
    end
    initial
    begin
        void'($urandom(27608));
        repeat (7) @(posedge sys_clk);
        #1 chkDec;
        @(posedge sys_clk);
        rst <= 0;
        for (int d = 0; d < 64; d++) cfg(0, d[5:0], 4'hf);
        // all select codes with both vga settings, noise on reserved bits
        for (int k = 0; k < 16; k++)
        begin
            @(posedge sys_clk);
            hostGfxCtrl <= 16'($urandom) & ~16'h0072
                | {9'h0, k[2:0], 2'b0, k[3], 1'b0};
            cfg(0, 6'h14, 4'hf);
            chkDec;
        end
        repeat (40) cfg(1, 6'($urandom_range(15, 20)), 4'($urandom));
        for (int d = 15; d < 21; d++) cfg(0, d[5:0], 4'($urandom));
        // frozen by ce: host change and request both wait
        @(posedge sys_clk);
        ce <= 0;
        cfgValid <= 1;
        hostGfxCtrl <= 16'h0032;
        repeat (3) @(posedge sys_clk);
        #1 chkDec;
        chk("frz", 0, cfgDone);
        @(posedge sys_clk);
        ce <= 1;
        cfgValid <= 0;
        cfg(0, 6'h14, 4'hf);
        chkDec;
        @(posedge sys_clk);
        smmMemoryLock <= 1;
        hostGfxCtrl <= 16'h0002;
        @(posedge sys_clk);
        smmMemoryLock <= 0;
        hostGfxCtrl <= 16'h0010;
        cfg(0, 6'h14, 4'hf);
        chkDec;
        // lock only clears by reset; mirror follows the host again
        @(posedge sys_clk);
        rst <= 1;
        repeat (2) @(posedge sys_clk);
        rst <= 0;
        cfg(0, 6'h14, 4'hf);
        chkDec;
        end_of_test;
    end
endmodule // tb_top
bind gmc_config_regs gmc_config_monitor u_gmc_config_monitor (
    .sys_clk          (sys_clk),
    .rst              (rst),
    .ce               (ce),
    .cfgValid         (cfgValid),
    .cfgWrite         (cfgWrite),
    .cfgDword         (cfgDword),
    .cfgByteEn        (cfgByteEn),
    .cfgWrData        (cfgWrData),
    .hostGfxCtrl      (hostGfxCtrl),
    .smmMemoryLock    (smmMemoryLock),
    .cfgDone          (cfgDone),
    .cfgRdData        (cfgRdData),
    .cfgHit           (cfgHit),
    .writeIgnored     (writeIgnored),
    .gfxCtrlLocked    (gfxCtrlLocked),
    .vgaClaim         (vgaClaim),
    .subClassCode     (subClassCode),
    .preallocMb       (preallocMb),
    .preallocReserved (preallocReserved)
);
`default_nettype wire
